// >>> design/floppy_drive_select_regs.sv
`timescale 1ns/1ps
`include "fdc_sel_cfg.svh"

module floppy_drive_select_regs
    import fdc_sel_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire host_bus_t host,
    input wire status_mode_t status_mode,
    input wire logic enhanced_mode2,
    input wire logic drive_swap,
    input wire logic [7:0] drive_type_config,
    input wire disk_lines_t disk_lines,
    input wire dma_lines_t dma_core,
    output logic [7:0] data_out,
    output logic [7:0] data_oe_n,
    output logic drive_field0_n,
    output logic drive_field1_n,
    output logic motor_out0_n,
    output logic motor_out1_n,
    output logic soft_reset_n,
    output logic dma_pins_enable,
    output dma_lines_t dma_pins,
    output logic [3:0] dma_oe_n,
    output logic tape_access,
    output logic [1:0] tape_drive
);

    localparam logic [2:0] SRST_CYC = 3'(`SOFT_RESET_CYC);

    logic [5:0] doc_q;
    logic [1:0] tape_sel_q;
    logic [1:0] boot_drive_q;
    logic swap_q;
    logic rd_q;
    logic wr_q;
    logic rd_start;
    logic wr_start;
    logic [2:0] flag_q;
    logic [2:1] toggle_q;
    logic [2:0] srst_cnt_q;
    logic soft_reset_n_q;
    logic sel0_n_q;
    logic sel1_n_q;
    logic mot0_n_q;
    logic mot1_n_q;
    logic dma_en_q;
    logic [7:0] data_out_q;
    logic [7:0] oe_n_d;
    logic [7:0] status_b;
    logic [7:0] tape_rd;
    logic [1:0] type_id;
    logic [1:0] field;
    logic mot0;
    logic mot1;
    logic sel_a_n;
    logic sel_b_n;
    logic dig_in_read;
    logic hit_status_b;
    logic hit_drive_out;
    logic hit_tape;
    logic hit_dig_in;
    logic pins_on;

    // Strobes are levels; act once on their leading cycle
    assign rd_start = ~host.rd_n & ~rd_q;
    assign wr_start = ~host.wr_n & ~wr_q;
    assign dig_in_read = rd_start && hit_dig_in;

    // One decoder feeds the read enables and the clear strobe
    always_comb begin
        hit_status_b = 1'b0;
        hit_drive_out = 1'b0;
        hit_tape = 1'b0;
        hit_dig_in = 1'b0;
        if (host.addr == `ADDR_STATUS_B) begin
            hit_status_b = 1'b1;
        end else if (host.addr == `ADDR_DRIVE_OUT) begin
            hit_drive_out = 1'b1;
        end else if (host.addr == `ADDR_TAPE) begin
            hit_tape = 1'b1;
        end else if (host.addr == `ADDR_DIG_IN) begin
            hit_dig_in = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end else begin
            rd_q <= ~host.rd_n;
            wr_q <= ~host.wr_n;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            swap_q <= 1'b0;
        end else begin
            swap_q <= drive_swap;
        end
    end

    // Only the hardware reset, not the soft reset bit, clears this register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            doc_q <= `DOC_RESET_VAL;
        end else if (wr_start && host.addr == `ADDR_DRIVE_OUT) begin
            doc_q <= host.wdata[5:0];
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tape_sel_q <= `TAPE_RESET_VAL;
            boot_drive_q <= 2'h0;
        end else if (wr_start && host.addr == `ADDR_TAPE) begin
            tape_sel_q <= host.wdata[1:0];
            if (enhanced_mode2) begin
                boot_drive_q <= host.wdata[3:2];
            end
        end
    end

    // Stretch so a zero-then-one pair still meets the least width
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            srst_cnt_q <= 3'h0;
            soft_reset_n_q <= 1'b0;
        end else begin
            if (!doc_q[`DOC_RESET_BIT]) begin
                srst_cnt_q <= SRST_CYC;
            end else if (srst_cnt_q != 3'h0) begin
                srst_cnt_q <= srst_cnt_q - 3'h1;
            end
            soft_reset_n_q <= doc_q[`DOC_RESET_BIT]
                && (srst_cnt_q <= 3'h1);
        end
    end

    assign field = doc_q[`DOC_FIELD_MSB:`DOC_FIELD_LSB];
    assign mot0 = doc_q[`DOC_MOT0_BIT];
    assign mot1 = doc_q[`DOC_MOT1_BIT];
    // Fields 10 and 11 select nothing: drives 2 and 3 absent
    assign sel_a_n = ~(field == 2'h0 && mot0);
    assign sel_b_n = ~(field == 2'h1 && mot1);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sel0_n_q <= 1'b1;
            sel1_n_q <= 1'b1;
            mot0_n_q <= 1'b1;
            mot1_n_q <= 1'b1;
        end else if (swap_q) begin
            sel0_n_q <= sel_b_n;
            sel1_n_q <= sel_a_n;
            mot0_n_q <= ~mot1;
            mot1_n_q <= ~mot0;
        end else begin
            sel0_n_q <= sel_a_n;
            sel1_n_q <= sel_b_n;
            mot0_n_q <= ~mot0;
            mot1_n_q <= ~mot1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dma_en_q <= 1'b0;
        end else if (status_mode == MODE_FULL_STATUS) begin
            dma_en_q <= 1'b1;
        end else begin
            dma_en_q <= doc_q[`DOC_DMA_BIT];
        end
    end

    // Full status mode keeps the pins live even while reset clears the bit,
    // so this term must not come from a flop
    assign pins_on = dma_en_q || status_mode == MODE_FULL_STATUS;

    // Disabled acknowledge and terminal count read as idle
    assign dma_pins.drq = dma_core.drq;
    assign dma_pins.floppy_irq = dma_core.floppy_irq;
    assign dma_pins.dack_n = dma_core.dack_n | ~pins_on;
    assign dma_pins.tc = dma_core.tc & pins_on;
    assign dma_oe_n = {~pins_on, ~pins_on, 2'b11};

    disk_edge_flags u_flags (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .lines(disk_lines),
        .clear(dig_in_read),
        .flag_q(flag_q),
        .toggle_q(toggle_q)
    );

    always_comb begin
        if (status_mode == MODE_ALT_STATUS) begin
            status_b = {1'b1,
                        sel1_n_q, sel0_n_q,
                        flag_q[`FLAG_WDATA], flag_q[`FLAG_RDATA],
                        flag_q[`FLAG_WRITE_GATE],
                        2'b11};
        end else begin
            status_b = {2'b11, doc_q[`DOC_FIELD_LSB], toggle_q[2],
                        toggle_q[1], disk_lines.write_gate,
                        ~mot1_n_q, ~mot0_n_q};
        end
    end

    always_comb begin
        case (field)
            2'h0: type_id = drive_type_config[1:0];
            2'h1: type_id = drive_type_config[3:2];
            2'h2: type_id = drive_type_config[5:4];
            default: type_id = drive_type_config[7:6];
        endcase
    end

    assign tape_rd = enhanced_mode2
        ? {2'b00, type_id, boot_drive_q, tape_sel_q}
        : {6'h00, tape_sel_q};

    always_comb begin
        oe_n_d = 8'hff;
        if (host.rd_n) begin
            oe_n_d = 8'hff;
        end else if (hit_status_b) begin
            if (status_mode != MODE_LEGACY) begin
                oe_n_d = 8'h00;
            end
        end else if (hit_drive_out) begin
            oe_n_d = 8'h00;
        end else if (hit_tape) begin
            oe_n_d = enhanced_mode2 ? 8'h00 : 8'hfc;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            data_out_q <= 8'h00;
        end else if (host.addr == `ADDR_STATUS_B) begin
            data_out_q <= status_b;
        end else if (host.addr == `ADDR_DRIVE_OUT) begin
            data_out_q <= {2'b00, doc_q};
        end else if (host.addr == `ADDR_TAPE) begin
            data_out_q <= tape_rd;
        end else begin
            data_out_q <= 8'h00;
        end
    end

    assign data_out = data_out_q;
    assign data_oe_n = oe_n_d;
    assign drive_field0_n = sel0_n_q;
    assign drive_field1_n = sel1_n_q;
    assign motor_out0_n = mot0_n_q;
    assign motor_out1_n = mot1_n_q;
    assign soft_reset_n = soft_reset_n_q;
    assign dma_pins_enable = dma_en_q;
    assign tape_drive = tape_sel_q;
    // Drive 0 never matches: encoding 00 means no tape drive
    assign tape_access = tape_sel_q != 2'h0
        && tape_sel_q == field;

endmodule

// >>> design/fdc_sel_cfg.svh
`ifndef FDC_SEL_CFG_SVH
`define FDC_SEL_CFG_SVH

// Host port addresses (primary base)
`define ADDR_STATUS_B 10'h3f1
`define ADDR_DRIVE_OUT 10'h3f2
`define ADDR_TAPE 10'h3f3
`define ADDR_DIG_IN 10'h3f7

// Drive output control fields
`define DOC_FIELD_LSB 0
`define DOC_FIELD_MSB 1
`define DOC_RESET_BIT 2
`define DOC_DMA_BIT 3
`define DOC_MOT0_BIT 4
`define DOC_MOT1_BIT 5
`define DOC_RESET_VAL 6'h00
`define TAPE_RESET_VAL 2'h0

// Status flag lanes inside the edge catcher
`define FLAG_WRITE_GATE 0
`define FLAG_RDATA 1
`define FLAG_WDATA 2
`define FLAG_RISE_MASK 3'h1

// Soft reset least width
`define CLK_MHZ 40
`define SOFT_RESET_MIN_NS 100
`define SOFT_RESET_CYC ((`SOFT_RESET_MIN_NS * `CLK_MHZ + 999) / 1000)

`endif

// >>> design/fdc_sel_pkg.sv
package fdc_sel_pkg;

    typedef enum logic [1:0] {
        MODE_LEGACY,
        MODE_FULL_STATUS,
        MODE_ALT_STATUS
    } status_mode_t;

    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic [9:0] addr;
        logic [7:0] wdata;
    } host_bus_t;

    // Active-high internal levels of the disk interface signals
    typedef struct packed {
        logic write_data;
        logic read_data;
        logic write_gate;
    } disk_lines_t;

    typedef struct packed {
        logic drq;
        logic floppy_irq;
        logic dack_n;
        logic tc;
    } dma_lines_t;

endpackage

// >>> design/disk_edge_flags.sv
`timescale 1ns/1ps
`include "fdc_sel_cfg.svh"

module disk_edge_flags
    import fdc_sel_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire disk_lines_t lines,
    input wire logic clear,
    output logic [2:0] flag_q,
    output logic [2:1] toggle_q
);

    logic [2:0] level;
    logic [2:0] prev_q;
    localparam logic [2:0] RISE = `FLAG_RISE_MASK;

    assign level = lines;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_q <= 3'h0;
        end else begin
            prev_q <= level;
        end
    end

    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_flag
            logic hit;
            assign hit = RISE[i] ? (level[i] & ~prev_q[i])
                                 : (~level[i] & prev_q[i]);
            // Edge in the clearing cycle still sets the flag
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    flag_q[i] <= 1'b0;
                end else if (hit) begin
                    flag_q[i] <= 1'b1;
                end else if (clear) begin
                    flag_q[i] <= 1'b0;
                end
            end
            if (i > 0) begin : g_tog
                always_ff @(posedge sys_clk or negedge reset_n) begin
                    if (!reset_n) begin
                        toggle_q[i] <= 1'b0;
                    end else if (hit) begin
                        toggle_q[i] <= ~toggle_q[i];
                    end
                end
            end
        end
    endgenerate

endmodule

// >>> tb/fdc_sel_properties.sv
`timescale 1ns/1ps
module fdc_sel_checker
    import fdc_sel_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire host_bus_t host,
    input wire status_mode_t status_mode,
    input wire logic enhanced_mode2,
    input wire logic [7:0] data_out,
    input wire logic [7:0] data_oe_n,
    input wire logic drive_field0_n,
    input wire logic drive_field1_n,
    input wire logic soft_reset_n,
    input wire dma_lines_t dma_pins,
    input wire logic [3:0] dma_oe_n,
    input wire logic tape_access
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    property p_one_sel;
        !(!drive_field0_n && !drive_field1_n);
    endproperty
    a_one_sel: assert property (p_one_sel)
        else $error("both selects low");
    property p_legacy_float;
        status_mode == MODE_LEGACY && !host.rd_n && host.addr == 10'h3f1
            |-> data_oe_n == 8'hff;
    endproperty
    a_legacy_float: assert property (p_legacy_float)
        else $error("status b driven in legacy mode");
    property p_tape_float;
        !enhanced_mode2 && !host.rd_n && host.addr == 10'h3f3
            |-> data_oe_n[7:2] == 6'h3f;
    endproperty
    a_tape_float: assert property (p_tape_float)
        else $error("tape upper bits driven");
    property p_full_dma;
        status_mode == MODE_FULL_STATUS && $past(status_mode) == status_mode
            && $past(reset_n) |-> dma_oe_n[3:2] == 2'b00;
    endproperty
    a_full_dma: assert property (p_full_dma)
        else $error("dma pins off in full mode");
    property p_dma_off;
        dma_oe_n[3] |-> dma_oe_n[2] && dma_pins.dack_n && !dma_pins.tc;
    endproperty
    a_dma_off: assert property (p_dma_off)
        else $error("disabled dma inputs not ignored");
    property p_srst_len;
        $fell(soft_reset_n) |-> !soft_reset_n [*4];
    endproperty
    a_srst_len: assert property (p_srst_len)
        else $error("soft reset too short");
    property p_srb_ones;
        status_mode == MODE_ALT_STATUS && $stable(status_mode)
            && host.addr == 10'h3f1 && $stable(host.addr) && $past(reset_n)
            |-> data_out[7] && data_out[1:0] == 2'b11;
    endproperty
    a_srb_ones: assert property (p_srb_ones)
        else $error("status b fixed bits wrong");
    property p_mot_hi;
        host.addr == 10'h3f2 && $stable(host.addr) && $past(reset_n)
            |-> data_out[7:6] == 2'b00;
    endproperty
    a_mot_hi: assert property (p_mot_hi)
        else $error("upper motor bits not zero");
    c_srst: cover property ($fell(soft_reset_n));
    c_tape: cover property (tape_access);
    c_sel1: cover property (!drive_field1_n);
endmodule
bind floppy_drive_select_regs fdc_sel_checker fdc_sel_checker_i (.*);

// >>> tb/disk_side_model.sv
`timescale 1ns/1ps
module disk_side_model
    import fdc_sel_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [2:0] pulse_req,
    output disk_lines_t disk_lines,
    output dma_lines_t dma_core
);
    disk_lines_t lines_q = '0;
    logic [3:0] cnt_q = 4'h0;
    // Lines follow the request one cycle late, like a slow drive
    always @(posedge sys_clk) begin
        lines_q <= disk_lines_t'(pulse_req);
        cnt_q <= cnt_q + 4'h1;
    end
    assign disk_lines = lines_q;
    // Changes every cycle so a stuck pass-through shows
    assign dma_core = dma_lines_t'(cnt_q);
endmodule

// >>> tb/floppy_drive_select_regs_tb.sv
`timescale 1ns/1ps
module floppy_drive_select_regs_tb
    import fdc_sel_pkg::*;
;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    host_bus_t host = {2'b11, 18'h00000};
    status_mode_t status_mode = MODE_LEGACY;
    logic enhanced_mode2 = 1'b0;
    logic drive_swap = 1'b0;
    logic [7:0] drive_type_config = 8'h9c;
    logic [2:0] pulse_req = 3'h0;
    disk_lines_t disk_lines;
    dma_lines_t dma_core, dma_pins;
    logic [7:0] data_out, data_oe_n;
    logic drive_field0_n, drive_field1_n, motor_out0_n, motor_out1_n;
    logic soft_reset_n, dma_pins_enable, tape_access;
    logic [3:0] dma_oe_n;
    logic [1:0] tape_drive;
    int n_fail = 0;
    int checks = 0;
    // swap, written, read back, {sel1_n, sel0_n, mot1_n, mot0_n}
    logic [20:0] rows [7] = '{{1'b0, 8'h1c, 8'h1c, 4'ha},
        {1'b0, 8'h2d, 8'h2d, 4'h5}, {1'b0, 8'hfe, 8'h3e, 4'hc},
        {1'b0, 8'h0f, 8'h0f, 4'hf}, {1'b0, 8'h2c, 8'h2c, 4'hd},
        {1'b1, 8'h1c, 8'h1c, 4'h5}, {1'b1, 8'h2d, 8'h2d, 4'ha}};

    floppy_drive_select_regs floppy_drive_select_regs_i (.*);
    disk_side_model disk_side_model_i (.*);

    always #12.5 sys_clk = ~sys_clk;

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            n_fail++;
        end
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d, input int w);
        @(posedge sys_clk);
        host <= {2'b10, a, d};
        repeat (2) @(posedge sys_clk);
        host.wr_n <= 1'b1;
        repeat (w) @(posedge sys_clk);
    endtask

    task automatic rd(input logic [9:0] a, input logic [7:0] m, e, oe);
        @(posedge sys_clk);
        host <= {2'b01, a, 8'h00};
        repeat (2) @(posedge sys_clk);
        #1;
        check(data_oe_n, oe);
        check(data_out & m, e);
        @(posedge sys_clk);
        host.rd_n <= 1'b1;
    endtask

    task automatic pulse(input logic [2:0] p);
        @(posedge sys_clk);
        pulse_req <= p;
        repeat (2) @(posedge sys_clk);
        pulse_req <= 3'h0;
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge sys_clk);
        n_fail++;
        tally_and_finish;
    end

    initial begin
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            drive_swap <= rows[i][20];
            wr(10'h3f2, rows[i][19:12], 8);
            check({drive_field1_n, drive_field0_n, motor_out1_n, motor_out0_n},
                {4'h0, rows[i][3:0]});
            rd(10'h3f2, 8'hff, rows[i][11:4], 8'h00);
            check(soft_reset_n, 1'b1);
        end
        drive_swap <= 1'b0;
        wr(10'h3f2, 8'h1c, 8);
        status_mode <= MODE_ALT_STATUS;
        rd(10'h3f7, 8'h00, 8'h00, 8'hff);
        rd(10'h3f1, 8'hff, 8'hc3, 8'h00);
        for (int k = 0; k < 3; k++) begin
            pulse(3'h1 << k);
            rd(10'h3f1, 8'hff, 8'hc3 | ((8'h08 << k) - 8'h04),
                8'h00);
        end
        rd(10'h3f7, 8'h00, 8'h00, 8'hff);
        rd(10'h3f1, 8'hff, 8'hc3, 8'h00);
        status_mode <= MODE_LEGACY;
        rd(10'h3f1, 8'h00, 8'h00, 8'hff);
        wr(10'h3f2, 8'h18, 8);
        check({soft_reset_n, drive_field0_n, motor_out0_n}, 8'h00);
        rd(10'h3f2, 8'hff, 8'h18, 8'h00);
        wr(10'h3f2, 8'h1c, 8);
        wr(10'h3f2, 8'h18, 0);
        wr(10'h3f2, 8'h1c, 8);
        check(soft_reset_n, 1'b1);
        wr(10'h3f3, 8'hfe, 2);
        rd(10'h3f3, 8'h03, 8'h02, 8'hfc);
        enhanced_mode2 <= 1'b1;
        wr(10'h3f3, 8'h0e, 2);
        for (int f = 0; f < 4; f++) begin
            wr(10'h3f2, {6'h01, f[1:0]}, 8);
            rd(10'h3f3, 8'hff, {2'b00, drive_type_config[2*f +: 2], 4'he},
                8'h00);
            check(tape_access, f == 2);
        end
        check(dma_oe_n, 8'h0f);
        wr(10'h3f2, 8'h0c, 4);
        #1;
        check(dma_oe_n, 8'h03);
        check(dma_pins.drq, dma_core.drq);
        wr(10'h3f2, 8'h04, 2);
        status_mode <= MODE_FULL_STATUS;
        repeat (3) @(posedge sys_clk);
        #1;
        check(dma_oe_n, 8'h03);
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (10) @(posedge sys_clk);
        #1;
        check(dma_oe_n, 8'h03);
        check(dma_pins_enable, 1'b0);
        @(posedge sys_clk);
        status_mode <= MODE_LEGACY;
        reset_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        check({drive_field1_n, drive_field0_n, motor_out1_n, soft_reset_n},
            8'h0e);
        rd(10'h3f2, 8'hff, 8'h00, 8'h00);
        tally_and_finish;
    end
endmodule
